// ---- bench/ibp_host_model.sv ----
module ibp_host_model (
  input  wire logic       CLK_I,
  input  wire logic       DRQ_I,
  input  wire logic [3:0] LAT_I,
  input  wire logic       REF_GO_I,
  output logic            DACK_B_O,
  output logic            REF_B_O
);
  timeunit 1ns;
  timeprecision 1ns;

  int wait_cnt = 0;

  initial begin
    DACK_B_O = 1'b1;
    REF_B_O  = 1'b1;
    forever begin
      @(negedge CLK_I);
      if (REF_GO_I === 1'b1) begin
        // some boards raise a false acknowledge inside refresh
        REF_B_O <= 1'b0;
        repeat (2) @(negedge CLK_I);
        DACK_B_O <= 1'b0;
        repeat (2) @(negedge CLK_I);
        DACK_B_O <= 1'b1;
        @(negedge CLK_I);
        REF_B_O <= 1'b1;
      end else if (DRQ_I === 1'b1) begin
        // grant after LAT_I cycles; address, data, commands float from here
        wait_cnt++;
        if (wait_cnt >= LAT_I) DACK_B_O <= 1'b0;
      end else begin
        // request gone: acknowledge withdrawn, bus taken back
        wait_cnt = 0;
        DACK_B_O <= 1'b1;
      end
    end
  end
endmodule

// ---- bench/ibp_isa_port_test.sv ----
module ibp_isa_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ibp_pkg::*;

  logic CLK_I = 0, RST_B_I = 0, AEN_I = 1, IO_SEL_I = 0, SBHE_B_I = 1;
  logic IOR_B_I = 1, IOW_B_I = 1, MEMR_B_I = 1, BOOT_SEL_I = 0;
  logic IO16_EN_I = 0, PROM_INT_I = 0, PRIVATE_DATA_BUS_BUSY_I = 0, REG_ACK_I = 0;
  logic MST_REQ_I = 0, ref_go = 0, ack_due = 0;
  logic [4:0]   SA_I = 5'h00;
  logic [7:0]   PRD_I = 8'h00;
  logic [3:0]   lat = 4'h1;
  logic [15:0]  SD_I = 16'h0000, REG_RDATA_I = 16'h0000, rd_next = 16'h0000;
  logic [15:0]  SD_O, g_rd, w, r;
  ibp_load_type LOAD_I = '0;
  ibp_reg_type  REG_O, cap;
  logic SD_LO_OE_O, SD_HI_OE_O, IOCHRDY_OE_O, IOCS16_OE_O, ADDR_PROM_SELECT_O;
  logic BOOT_PROM_SELECT_O, SOFT_RST_O, DACK_B_I, REF_B_I, DRQ_O, MASTER_B_O;
  logic BUS_OE_O, CMD_EN_O, g_width_acknowledge, g_lo, g_hi, g_rdy, g_srst;
  logic [7:0]   station [16];
  int           err_total = 0, check_count = 0, req_cnt = 0, n;

  ibp_isa_port uut (
    .CLK_I, .RST_B_I, .AEN_I, .IO_SEL_I, .SA_I, .SBHE_B_I, .IOR_B_I,
    .IOW_B_I, .MEMR_B_I, .REF_B_I, .BOOT_SEL_I, .SD_I, .SD_O, .SD_LO_OE_O,
    .SD_HI_OE_O, .IOCHRDY_OE_O, .IOCS16_OE_O, .IO16_EN_I, .PROM_INT_I,
    .PRIVATE_DATA_BUS_BUSY_I, .PRD_I, .ADDR_PROM_SELECT_O, .BOOT_PROM_SELECT_O, .LOAD_I,
    .REG_O, .REG_ACK_I, .REG_RDATA_I, .SOFT_RST_O, .DACK_B_I, .MST_REQ_I,
    .DRQ_O, .MASTER_B_O, .BUS_OE_O, .CMD_EN_O
  );
  ibp_host_model host (.CLK_I, .DRQ_I(DRQ_O), .LAT_I(lat), .REF_GO_I(ref_go),
    .DACK_B_O(DACK_B_I), .REF_B_O(REF_B_I));

  initial forever #50 CLK_I = ~CLK_I;

  ////////////////////////////////////////////////////////////////////////////
  // internal register side answers one cycle after the request pulse,
  // since an acknowledge beside the pulse itself is not taken
  always @(negedge CLK_I) begin
    REG_ACK_I <= 1'b0;
    if (ack_due) begin
      REG_ACK_I <= 1'b1;
      REG_RDATA_I <= rd_next;
    end
    ack_due = (REG_O.req === 1'b1);
    if (ack_due) begin
      req_cnt++;
      cap = REG_O;
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one i/o cycle; command held until ready is released and data is up
  task automatic io(input logic wr, input logic [4:0] ofs,
                    input logic sbhe_b, input logic [15:0] wd);
    int k;
    {g_width_acknowledge, g_lo, g_hi, g_rdy, g_srst} = '0;
    g_rd = 16'h0000;
    k = 0;
    AEN_I <= 1'b0;
    IO_SEL_I <= 1'b1;
    SA_I <= ofs;
    SBHE_B_I <= sbhe_b;
    SD_I <= wd;
    if (wr) IOW_B_I <= 1'b0;
    else IOR_B_I <= 1'b0;
    do begin
      @(negedge CLK_I);
      k++;
      g_width_acknowledge |= (IOCS16_OE_O === 1'b1);
      g_rdy |= (IOCHRDY_OE_O === 1'b1);
      g_srst |= (SOFT_RST_O === 1'b1);
      if (SD_LO_OE_O === 1'b1 || SD_HI_OE_O === 1'b1) begin
        {g_lo, g_hi, g_rd} = {SD_LO_OE_O, SD_HI_OE_O, SD_O};
      end
    end while (k < 12 && !(k >= 3 && IOCHRDY_OE_O !== 1'b1 &&
                           (wr || g_lo || g_hi)));
    {IOR_B_I, IOW_B_I, AEN_I} <= 3'b111;
    repeat (2) @(negedge CLK_I);
  endtask

  initial begin
    #(100 * 20000);
    err_total++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    w = $urandom(83558);
    repeat (6) @(negedge CLK_I);
    chk("idle", {REG_O.index[13:0], DRQ_O, MASTER_B_O}, 16'h0001);
    RST_B_I <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      station[i] = $urandom;
      LOAD_I <= {1'b1, i[3:0], station[i]};
      @(negedge CLK_I);
    end
    LOAD_I <= '0;
    IO16_EN_I <= 1'b1;
    w = $urandom;
    io(1, OFS_INDEX, 0, w);
    chk("index", REG_O.index, w);
    chk("wr ack", {g_width_acknowledge, g_rdy}, 2'b11);
    io(0, OFS_INDEX, 0, 16'h0000);
    chk("index rd", g_rd, w);
    chk("lanes", {g_lo, g_hi}, 2'b11);
    r = $urandom;
    io(1, OFS_DATA, 0, r);
    chk("word wr", cap.wdata, r);
    chk("wr kind", {cap.wr, cap.cfg}, 2'b10);
    rd_next = $urandom;
    io(0, OFS_CONFIG, 0, 16'h0000);
    chk("cfg rd", g_rd, rd_next);
    chk("cfg kind", {cap.wr, cap.cfg}, 2'b01);
    chk("cfg idx", cap.index, w);
    // reset port as a word read: no width ack, index back to zero
    io(0, OFS_RESET, 0, 16'h0000);
    chk("srst", {g_srst, g_width_acknowledge}, 2'b10);
    chk("index", REG_O.index, 16'h0000);
    io(1, OFS_INDEX, 0, w);
    io(1, OFS_RESET, 0, 16'hffff);
    chk("rst wr", {g_srst, g_rdy, REG_O.index == w}, 3'b001);
    // 8-bit ports: on data port writes the far lane carries the inverse to expose lane mixups
    IO16_EN_I <= 1'b0;
    n = req_cnt;
    w = $urandom;
    io(1, OFS_DATA, 1, {~w[7:0], w[7:0]});
    chk("held", 16'(req_cnt - n), 16'h0000);
    io(1, OFS_DATA + 5'h01, 0, {~w[15:8], w[15:8]});
    chk("merged", cap.wdata, w);
    chk("one req", 16'(req_cnt - n), 16'h0001);
    chk("width_acknowledge 8b", g_width_acknowledge, 0);
    io(1, OFS_INDEX, 1, {8'h00, w[7:0]});
    io(1, OFS_INDEX + 5'h01, 0, {8'h00, w[15:8]});
    chk("idx merged", REG_O.index, w);
    rd_next = $urandom;
    io(0, OFS_DATA + 5'h01, 0, 16'h0000);
    chk("odd rd", {g_hi, g_rd[7:0]}, {1'b0, rd_next[15:8]});
    io(0, OFS_DATA, 1, 16'h0000);
    chk("even rd", {g_hi, g_rd[7:0]}, {1'b0, rd_next[7:0]});
    for (int i = 24; i < 32; i++) begin
      io(0, 5'(i), 1, 16'h0000);
      chk("outside", {g_rdy, g_lo, g_hi}, 0);
    end
    PROM_INT_I <= 1'b1;
    io(1, 5'h03, 0, {8'h00, ~station[3]});
    for (int i = 0; i < 16; i++) begin
      io(0, 5'(i), !i[0], 16'h0000);
      chk("station", {g_hi, g_width_acknowledge, g_rd[7:0]}, {2'b00, station[i]});
    end
    // external prom waits for the private bus
    PROM_INT_I <= 1'b0;
    PRIVATE_DATA_BUS_BUSY_I <= 1'b1;
    PRD_I <= $urandom;
    fork
      io(0, 5'h05, 0, 16'h0000);
      begin
        repeat (3) @(negedge CLK_I);
        chk("wait", {IOCHRDY_OE_O, ADDR_PROM_SELECT_O, SD_LO_OE_O}, 4);
        PRIVATE_DATA_BUS_BUSY_I <= 1'b0;
      end
    join
    chk("prom", {g_hi, g_width_acknowledge, g_rd[7:0]}, {2'b00, PRD_I});
    chk("prom off", {ADDR_PROM_SELECT_O, SD_LO_OE_O}, 0);
    // boot read; address enable high must not matter
    PRD_I <= $urandom;
    MEMR_B_I <= 1'b0;
    BOOT_SEL_I <= 1'b1;
    n = 0;
    @(negedge CLK_I);
    chk("boot rdy", IOCHRDY_OE_O, 1);
    for (int k = 0; k < 12 && SD_LO_OE_O !== 1'b1; k++) begin
      n += (BOOT_PROM_SELECT_O === 1'b1);
      @(negedge CLK_I);
    end
    chk("boot sel", 16'(n), 16'h0003);
    chk("boot rd", {SD_HI_OE_O, IOCHRDY_OE_O, SD_O[7:0]}, {2'b00, PRD_I});
    {MEMR_B_I, BOOT_SEL_I} <= 2'b10;
    @(negedge CLK_I);
    chk("boot off", SD_LO_OE_O, 0);
    // first grant follows a refresh with a false acknowledge, then a slow one
    for (int k = 0; k < 2; k++) begin
      lat <= k ? 4'h6 : 4'h1;
      MST_REQ_I <= 1'b1;
      ref_go <= (k == 0);
      @(negedge CLK_I);
      ref_go <= 1'b0;
      chk("drq", DRQ_O, 1);
      n = 0;
      while (MASTER_B_O === 1'b1 && n < 20) begin
        @(negedge CLK_I);
        n++;
      end
      chk("grant", {MASTER_B_O, REF_B_I}, 2'b01);
      n = 0;
      while (BUS_OE_O !== 1'b1 && n < 8) begin
        @(negedge CLK_I);
        n++;
      end
      chk("settle", 16'(n), 16'(MST_SETTLE_CYC));
      chk("cmd", CMD_EN_O, 1);
      MST_REQ_I <= 1'b0;
      @(negedge CLK_I);
      chk("rel1", {CMD_EN_O, BUS_OE_O, DRQ_O, MASTER_B_O}, 4'b0110);
      @(negedge CLK_I);
      chk("rel2", {CMD_EN_O, BUS_OE_O, DRQ_O, MASTER_B_O}, 4'b0000);
      @(negedge CLK_I);
      chk("rel3", {CMD_EN_O, BUS_OE_O, DRQ_O, MASTER_B_O}, 4'b0001);
      repeat (2) @(negedge CLK_I);
    end
    summarize();
  end
endmodule

// ---- hdl/ibp_isa_port.sv ----
// Operation
// - ignore dack while refresh is active
// - non-16-bit slave reads use low lane
// - 8-bit odd write byte arrives on low lane
// - prom read holds ready, arbitrates private bus
// - prom select, low lane only, no width ack
// - internal station address copy, write protected
// - 8-bit register reads drive low lane only
// - even byte held, odd byte merges word
// - register cycle: ready low, width ack if enabled
// - reset port read resets all but transceiver
// - reset read no width ack, writes harmless
// - config registers via index then config port
// - boot prom read: ready low, one byte
// - boot select three cycles, prom enable tied
// - request dma, master after acknowledge
// - wait settle time before driving bus
// - master assumes 16-bit memory, no feedback
// - release: commands off, float, master off
// - any reset port read resets, writes ignored
// - no response at offsets 18h and above
// - index port cleared on reset
module ibp_isa_port
  import ibp_pkg::*;
(
  input  wire logic                 CLK_I,
  input  wire logic                 RST_B_I,
  input  wire logic                 AEN_I,
  input  wire logic                 IO_SEL_I,
  input  wire logic [4:0]           SA_I,
  input  wire logic                 SBHE_B_I,
  input  wire logic                 IOR_B_I,
  input  wire logic                 IOW_B_I,
  input  wire logic                 MEMR_B_I,
  input  wire logic                 REF_B_I,
  input  wire logic                 BOOT_SEL_I,
  input  wire logic [15:0]          SD_I,
  output logic      [15:0]          SD_O,
  output logic                      SD_LO_OE_O,
  output logic                      SD_HI_OE_O,
  output logic                      IOCHRDY_OE_O,
  output logic                      IOCS16_OE_O,
  input  wire logic                 IO16_EN_I,
  input  wire logic                 PROM_INT_I,
  input  wire logic                 PRIVATE_DATA_BUS_BUSY_I,
  input  wire logic [7:0]           PRD_I,
  output logic                      ADDR_PROM_SELECT_O,
  output logic                      BOOT_PROM_SELECT_O,
  input  wire ibp_pkg::ibp_load_type LOAD_I,
  output ibp_pkg::ibp_reg_type      REG_O,
  input  wire logic                 REG_ACK_I,
  input  wire logic [15:0]          REG_RDATA_I,
  output logic                      SOFT_RST_O,
  input  wire logic                 DACK_B_I,
  input  wire logic                 MST_REQ_I,
  output logic                      DRQ_O,
  output logic                      MASTER_B_O,
  output logic                      BUS_OE_O,
  output logic                      CMD_EN_O
);
  import ibp_pkg::*;

  typedef enum logic [5:0] {
    S_IDLE = 6'b00_0001,
    S_ARB  = 6'b00_0010,
    S_PSEL = 6'b00_0100,
    S_REG  = 6'b00_1000,
    S_BOOT = 6'b01_0000,
    S_HOLD = 6'b10_0000
  } ibp_slv_type;

  typedef enum logic [5:0] {
    M_IDLE   = 6'b00_0001,
    M_REQ    = 6'b00_0010,
    M_SETTLE = 6'b00_0100,
    M_OWN    = 6'b00_1000,
    M_CMDOFF = 6'b01_0000,
    M_FLOAT  = 6'b10_0000
  } ibp_mst_type;

  ibp_slv_type  slv_q;
  ibp_mst_type  mst_q;
  logic [7:0]   sta_ram [PROM_BYTES];
  logic [15:0]  index_q;
  logic [7:0]   hold_q;
  logic [15:0]  rdata_q;
  logic         lo_q;
  logic         hi_q;
  logic         is_mem_q;
  logic         width_acknowledge_q;
  logic         aps_q;
  logic [3:0]   cnt_q;
  logic         req_q;
  logic         dack_blk_q;
  logic         srst_q;

  logic         io_cyc;
  logic         mem_cyc;
  logic         is_rd;
  logic         reg_port;
  logic         odd;
  logic         word;
  logic [7:0]   odd_byte;
  logic         commit;
  logic [15:0]  wword;
  logic         cmd_on;
  logic         dack_ok;

  ////////////////////////////////////////////////////////////////////////
  // slave decode

  assign io_cyc   = !AEN_I && IO_SEL_I && (SA_I < OFS_LIMIT) &&
                    (!IOR_B_I || !IOW_B_I);
  assign mem_cyc  = BOOT_SEL_I && REF_B_I && !MEMR_B_I;
  assign is_rd    = !IOR_B_I;
  assign reg_port = (SA_I[4:1] == OFS_DATA[4:1]) ||
                    (SA_I[4:1] == OFS_INDEX[4:1]) ||
                    (SA_I[4:1] == OFS_CONFIG[4:1]);
  assign odd      = SA_I[0];
  assign word     = IO16_EN_I && !SA_I[0] && !SBHE_B_I;
  // 8-bit cycles: the current master has copied the odd byte down
  assign odd_byte = IO16_EN_I ? SD_I[15:8] : SD_I[7:0];
  assign commit   = odd || word;
  assign wword    = word ? SD_I : {odd_byte, hold_q};
  assign cmd_on   = is_mem_q ? !MEMR_B_I : (!IOR_B_I || !IOW_B_I);

  ////////////////////////////////////////////////////////////////////////
  // station address copy, written only by the loader

  always_ff @(posedge CLK_I) begin
    if (LOAD_I.we) begin
      sta_ram[LOAD_I.addr] <= LOAD_I.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // slave cycle sequencer

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      slv_q    <= S_IDLE;
      rdata_q  <= 16'h0000;
      lo_q     <= 1'b0;
      hi_q     <= 1'b0;
      is_mem_q <= 1'b0;
      width_acknowledge_q   <= 1'b0;
      aps_q    <= 1'b0;
      cnt_q    <= 4'h0;
      req_q    <= 1'b0;
    end else begin
      req_q <= 1'b0;
      unique case (slv_q)
        S_IDLE: begin
          lo_q  <= 1'b0;
          hi_q  <= 1'b0;
          aps_q <= 1'b0;
          if (mem_cyc) begin
            is_mem_q <= 1'b1;
            cnt_q    <= 4'h0;
            slv_q    <= S_BOOT;
          end else if (io_cyc) begin
            is_mem_q <= 1'b0;
            width_acknowledge_q   <= reg_port && IO16_EN_I;
            if (SA_I < OFS_PROM_END) begin
              if (!is_rd) begin
                slv_q <= S_HOLD;
              end else if (PROM_INT_I) begin
                rdata_q <= {8'h00, sta_ram[SA_I[3:0]]};
                lo_q    <= 1'b1;
                slv_q   <= S_HOLD;
              end else begin
                slv_q <= S_ARB;
              end
            end else if (SA_I[4:1] == OFS_RESET[4:1]) begin
              slv_q <= S_HOLD;
            end else begin
              req_q <= (SA_I[4:1] != OFS_INDEX[4:1]) && (is_rd || commit);
              slv_q <= S_REG;
            end
          end
        end
        S_ARB: begin
          if (!PRIVATE_DATA_BUS_BUSY_I) begin
            aps_q <= 1'b1;
            slv_q <= S_PSEL;
          end
        end
        S_PSEL: begin
          rdata_q <= {8'h00, PRD_I};
          lo_q    <= 1'b1;
          slv_q   <= S_HOLD;
        end
        S_REG: begin
          if (SA_I[4:1] == OFS_INDEX[4:1] || !req_q && REG_ACK_I ||
              !is_rd && !commit) begin
            if (is_rd) begin
              rdata_q <= (SA_I[4:1] == OFS_INDEX[4:1]) ? index_q
                                                       : REG_RDATA_I;
              if (!IO16_EN_I) begin
                if (odd) begin
                  rdata_q[7:0] <= (SA_I[4:1] == OFS_INDEX[4:1]) ?
                                  index_q[15:8] : REG_RDATA_I[15:8];
                end
                lo_q <= 1'b1;
              end else begin
                lo_q <= !odd;
                hi_q <= odd || !SBHE_B_I;
              end
            end
            slv_q <= S_HOLD;
          end
        end
        S_BOOT: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'(BOOT_SEL_CYC - 1)) begin
            rdata_q <= {8'h00, PRD_I};
            lo_q    <= 1'b1;
            slv_q   <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (!cmd_on) begin
            slv_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register ports; the reset port read also clears the index

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I || srst_q) begin
      index_q <= INDEX_RST;
      hold_q  <= 8'h00;
    end else if (slv_q == S_IDLE && io_cyc && !is_rd && reg_port) begin
      if (!commit) begin
        hold_q <= SD_I[7:0];
      end else if (SA_I[4:1] == OFS_INDEX[4:1]) begin
        index_q <= wword;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= slv_q == S_IDLE && io_cyc && is_rd &&
                SA_I[4:1] == OFS_RESET[4:1];
    end
  end

  // the core reset leaves the transceiver link state alone
  assign SOFT_RST_O = srst_q;
  assign REG_O      = '{req: req_q, wr: !is_rd,
                        cfg: SA_I[4:1] == OFS_CONFIG[4:1],
                        index: index_q, wdata: wword};

  // lanes drop with the command so the bus frees well inside 30 ns
  assign SD_O         = rdata_q;
  assign SD_LO_OE_O   = slv_q == S_HOLD && lo_q && cmd_on;
  assign SD_HI_OE_O   = slv_q == S_HOLD && hi_q && cmd_on;
  assign IOCHRDY_OE_O = (slv_q == S_ARB) || (slv_q == S_PSEL) ||
                        (slv_q == S_REG) || (slv_q == S_BOOT) ||
                        (slv_q == S_IDLE && (mem_cyc || io_cyc &&
                         (reg_port || is_rd && !PROM_INT_I &&
                          SA_I < OFS_PROM_END)));
  assign IOCS16_OE_O  = cmd_on && !is_mem_q && slv_q != S_IDLE && width_acknowledge_q;
  assign ADDR_PROM_SELECT_O = aps_q && slv_q != S_IDLE;
  assign BOOT_PROM_SELECT_O = slv_q == S_BOOT;

  ////////////////////////////////////////////////////////////////////////
  // bus master: obtain, access, release

  // some boards fake dack during refresh; once seen, wait for it to drop
  assign dack_ok = !DACK_B_I && REF_B_I && !dack_blk_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      dack_blk_q <= 1'b0;
    end else if (DACK_B_I) begin
      dack_blk_q <= 1'b0;
    end else if (!REF_B_I) begin
      dack_blk_q <= 1'b1;
    end
  end

  logic [3:0] mcnt_q;

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      mst_q  <= M_IDLE;
      mcnt_q <= 4'h0;
    end else begin
      mcnt_q <= mcnt_q + 4'h1;
      unique case (mst_q)
        M_IDLE: if (MST_REQ_I) mst_q <= M_REQ;
        M_REQ: begin
          mcnt_q <= 4'h0;
          if (dack_ok) mst_q <= M_SETTLE;
        end
        M_SETTLE: begin
          if (mcnt_q == 4'(MST_SETTLE_CYC - 1)) begin
            mst_q <= M_OWN;
          end
        end
        M_OWN: begin
          mcnt_q <= 4'h0;
          if (!MST_REQ_I) mst_q <= M_CMDOFF;
        end
        M_CMDOFF: begin
          if (mcnt_q == 4'(MST_REL_CYC - 1)) begin
            mcnt_q <= 4'h0;
            mst_q  <= M_FLOAT;
          end
        end
        M_FLOAT: begin
          if (mcnt_q == 4'(MST_REL_CYC - 1)) mst_q <= M_IDLE;
        end
      endcase
    end
  end

  assign DRQ_O      = mst_q inside {M_REQ, M_SETTLE, M_OWN, M_CMDOFF};
  assign MASTER_B_O = !(mst_q inside {M_SETTLE, M_OWN, M_CMDOFF,
                                      M_FLOAT});
  assign BUS_OE_O   = mst_q inside {M_OWN, M_CMDOFF};
  // fixed command width, ready and width acknowledge are not sampled
  assign CMD_EN_O   = mst_q == M_OWN;

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_dack_refresh_ign: assert property (@(posedge CLK_I) disable iff
    (!RST_B_I) mst_q == M_REQ && !REF_B_I |=> mst_q == M_REQ)
    else $error("dack taken during refresh");
  a_prom_ready_hold: assert property (@(posedge CLK_I) disable iff
    (!RST_B_I) slv_q == S_ARB |-> IOCHRDY_OE_O && !SD_LO_OE_O)
    else $error("prom wait not held");
  a_prom_low_lane: assert property (@(posedge CLK_I) disable iff
    (!RST_B_I) aps_q && slv_q == S_HOLD |-> !SD_HI_OE_O && !IOCS16_OE_O
    && ADDR_PROM_SELECT_O)
    else $error("prom cycle lanes wrong");
  a_reg_lane_8bit: assert property (@(posedge CLK_I) disable iff
    (!RST_B_I) !IO16_EN_I && $stable(IO16_EN_I) |-> !SD_HI_OE_O)
    else $error("high lane driven in 8-bit mode");
  a_merge_write: assert property (@(posedge CLK_I) disable iff
    (!RST_B_I) slv_q == S_IDLE && io_cyc && !is_rd && !IO16_EN_I &&
    SA_I == OFS_INDEX + 5'h01 |=> index_q == {$past(SD_I[7:0]),
    $past(hold_q)})
    else $error("odd byte not merged");
  a_reg_ready_low: assert property (@(posedge CLK_I) disable iff
    (!RST_B_I) slv_q == S_IDLE && io_cyc && reg_port |-> IOCHRDY_OE_O
    ##1 IOCS16_OE_O == IO16_EN_I || !cmd_on)
    else $error("register cycle handshake wrong");
  a_reset_no_width_acknowledge: assert property (@(posedge CLK_I) disable iff
    (!RST_B_I) slv_q == S_IDLE && io_cyc && is_rd &&
    SA_I[4:1] == OFS_RESET[4:1] |=> SOFT_RST_O && !IOCS16_OE_O ##1
    index_q == INDEX_RST)
    else $error("reset port read wrong");
  a_no_high_decode: assert property (@(posedge CLK_I) disable iff
    (!RST_B_I) slv_q == S_IDLE && SA_I >= OFS_LIMIT && !mem_cyc |=>
    slv_q == S_IDLE)
    else $error("answered above block");
  a_bootsel_width: assert property (@(posedge CLK_I) disable iff
    (!RST_B_I) $rose(BOOT_PROM_SELECT_O) |-> BOOT_PROM_SELECT_O [*3]
    ##1 !BOOT_PROM_SELECT_O)
    else $error("boot select width wrong");
  a_master_settle: assert property (@(posedge CLK_I) disable iff
    (!RST_B_I) $fell(MASTER_B_O) |-> !BUS_OE_O [*2] ##1 BUS_OE_O)
    else $error("bus driven before settle");
  a_release_order: assert property (@(posedge CLK_I) disable iff
    (!RST_B_I) $fell(CMD_EN_O) && !MASTER_B_O |-> BUS_OE_O && DRQ_O
    ##1 !BUS_OE_O && !DRQ_O && !MASTER_B_O ##1 MASTER_B_O)
    else $error("release order wrong");

  c_boot_read: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
    slv_q == S_BOOT ##3 SD_LO_OE_O);
  c_prom_arb: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
    slv_q == S_ARB ##[1:20] ADDR_PROM_SELECT_O);
  c_master_own: cover property (@(posedge CLK_I) disable iff (!RST_B_I)
    mst_q == M_OWN ##[1:50] MASTER_B_O);
endmodule

// ---- hdl/ibp_pkg.sv ----
package ibp_pkg;

  // i/o offsets inside the 24-byte block
  localparam logic [4:0] OFS_PROM_END = 5'h10;
  localparam logic [4:0] OFS_DATA     = 5'h10;
  localparam logic [4:0] OFS_INDEX    = 5'h12;
  localparam logic [4:0] OFS_RESET    = 5'h14;
  localparam logic [4:0] OFS_CONFIG   = 5'h16;
  localparam logic [4:0] OFS_LIMIT    = 5'h18;
  localparam int         PROM_BYTES   = 16;

  localparam logic [15:0] INDEX_RST   = 16'h0000;

  // timing, figures in ns, counts derived for the 10 MHz clock
  localparam int CLK_MHZ       = 10;
  localparam int SD_OFF_NS     = 30;
  localparam int BOOT_SEL_NS   = 300;
  localparam int BOOT_RESP_NS  = 275;
  localparam int MST_SETTLE_NS = 150;
  localparam int MST_REL_NS    = 50;

  localparam int SD_OFF_CYC    = (SD_OFF_NS * CLK_MHZ / 1000 < 1) ? 1 :
                                 SD_OFF_NS * CLK_MHZ / 1000;
  localparam int BOOT_SEL_CYC  = (BOOT_SEL_NS * CLK_MHZ + 999) / 1000;
  localparam int BOOT_RESP_CYC = (BOOT_RESP_NS * CLK_MHZ + 999) / 1000;
  localparam int MST_SETTLE_CYC = (MST_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int MST_REL_CYC   = (MST_REL_NS * CLK_MHZ + 999) / 1000;

  // station address load from the eeprom loader
  typedef struct packed {
    logic       we;
    logic [3:0] addr;
    logic [7:0] data;
  } ibp_load_type;

  // internal register port request
  typedef struct packed {
    logic        req;
    logic        wr;
    logic        cfg;
    logic [15:0] index;
    logic [15:0] wdata;
  } ibp_reg_type;

endpackage
